// ==== core/pic_ctrl.sv ====
// Prioritized interrupt controller: latches, enables, acknowledge and return
`timescale 1ns/1ps
`include "pic_defines.svh"

// What this block does
// [RULE1] Six sources, each with its own request latch
// [RULE2] Fixed priority: high pin, serial, timers, interval, low
// [RULE3] Vectors 002h to 00Ch, highest priority first
// [RULE4] Master flag at 0 blocks every acceptance
// [RULE5] Four enable bits: serial, timer1, timer2, low pin
// [RULE6] Enable bit1 gates timer2 and interval together
// [RULE7] High pin needs only the master flag
// [RULE8] Enable mask swapped with accumulator, old returned
// [RULE9] Reset clears master flag, enables, all latches
// [RULE10] Latch stays until accepted, reset or cleared
// [RULE11] Clear mask zeros clear; variants set/clear master
// [RULE12] Instructions can never set a latch
// [RULE13] Acknowledge after instruction end, two instruction cycles
// [RULE14] Acknowledge pushes, vectors, sets status, clears flags
// [RULE15] Return pops stack and sets master flag
// [RULE16] Software saves accumulator and working registers itself
// [RULE17] External latches set on settled falling pin edge
// [RULE18] Pin levels held two instruction cycles each
// [RULE19] Instruction cycle is four states of two clocks
// [RULE20] Simultaneous request and clear leaves latch set
// [RULE21] Evaluate at boundaries, freeze winner at acknowledge start
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int PC_W = 12
) (
  input  wire logic                   clock,                 // 100 MHz system clock
  input  wire logic                   rst,                   // Synchronous reset, active high
  input  wire logic                   ext_pin_high_prio_irq, // High priority pin, async
  input  wire logic                   ext_pin_low_prio_irq,  // Low priority pin, async
  input  wire pic_int_req_t           int_req,               // Internal request pulses
  input  wire logic                   inst_end,              // Core: instruction completes
  input  wire logic                   tc_busy,               // Core: timer processing pending
  input  wire pic_clr_cmd_t           clr_cmd,               // Latch-clearing instruction
  input  wire logic                   xch_strobe,            // Swap enable mask with acc
  input  wire logic [`PIC_EIR_W-1:0]  xch_data,              // Accumulator value to load
  input  wire logic                   return_from_irq,       // Return instruction strobe
  output logic      [`PIC_EIR_W-1:0]  xch_rd_data,           // Old mask to accumulator
  output logic      [`PIC_EIR_W-1:0]  source_enable_mask,    // Per-source enables
  output logic                        master_enable_flag,    // Master enable
  output logic      [`PIC_NSRC-1:0]   request_latch,         // Pending requests
  output logic                        ack_busy,              // Acknowledge in progress
  output logic                        stack_push,            // Save PC and flags
  output logic                        vector_load,           // Load vector into PC
  output logic      [PC_W-1:0]        vector_addr,           // Entry address
  output logic                        branch_status_set,     // Set status flag to 1
  output logic                        stack_pop,             // Restore PC and flags
  output logic                        ack_done               // Acknowledge finished
);

  // Highest set bit wins, bit order is priority order
  function automatic logic [`PIC_NSRC-1:0] pick_top(input logic [`PIC_NSRC-1:0] req);
    logic [`PIC_NSRC-1:0] hit;
    logic                 found;
    hit   = '0;
    found = 1'b0;
    for (int i = `PIC_NSRC - 1; i >= 0; i--)
    begin
      if (req[i] && !found)
      begin
        hit[i] = 1'b1;
        found  = 1'b1;
      end
    end
    return hit;
  endfunction

  // Entry address of a one-hot source
  function automatic logic [PC_W-1:0] vec_of(input logic [`PIC_NSRC-1:0] oh);
    logic [PC_W-1:0] vec;
    vec = '0;
    for (int i = 0; i < `PIC_NSRC; i++)
    begin
      if (oh[i])
      begin
        vec = PC_W'(`PIC_VEC_BASE + `PIC_VEC_STEP * (`PIC_NSRC - 1 - i));
      end
    end
    return vec;
  endfunction

  pic_state_t               state;
  pic_state_t               next_state;
  logic [`PIC_DIV_W-1:0]    div_cnt;
  logic [`PIC_NSRC-1:0]     win_q;
  logic [`PIC_NSRC-1:0]     next_latch;
  logic [1:0]               pin_fall;

  // External pins through the synchroniser
  pic_pin_sync #(
    .W (2)
  ) u_pin_sync (
    .clock  (clock),
    .rst    (rst),
    .pin_in ({ext_pin_high_prio_irq, ext_pin_low_prio_irq}),
    .fall   (pin_fall)
  );

  // Hardware set terms, one per latch
  wire [`PIC_NSRC-1:0] hw_set = {pin_fall[1],                      // RULE1
                                 int_req.serial_done_irq,
                                 int_req.timer_one_overflow_irq,
                                 int_req.timer_two_overflow_irq,
                                 int_req.interval_tick_irq,
                                 pin_fall[0]};

  // Per-source enables
  wire [`PIC_NSRC-1:0] src_en = {1'b1,                             // RULE7
                                 source_enable_mask[`PIC_EIR_SERIAL],   // RULE5
                                 source_enable_mask[`PIC_EIR_TIMER_ONE],
                                 source_enable_mask[`PIC_EIR_TIMER_TWO], // RULE6
                                 source_enable_mask[`PIC_EIR_TIMER_TWO],
                                 source_enable_mask[`PIC_EIR_EXT_LOW]};

  wire [`PIC_NSRC-1:0] eligible  = request_latch & src_en & {`PIC_NSRC{master_enable_flag}}; // RULE4
  wire                 req_go    = |eligible;
  wire [`PIC_NSRC-1:0] winner    = pick_top(eligible);             // RULE2
  wire [PC_W-1:0]      win_vec   = vec_of(winner);

  // Divider: one instruction cycle of eight clocks
  wire icyc_en = (div_cnt == `PIC_DIV_LAST);                       // RULE19

  // Acknowledge may start only at a boundary with no timer work
  wire at_boundary = (state == ST_IDLE && inst_end) || (state == ST_WAIT_TC);
  wire start_ack   = at_boundary && !tc_busy && req_go;            // RULE21 RULE13
  wire to_wait     = state == ST_IDLE && inst_end && tc_busy && req_go;

  // Latch clear sources
  wire [`PIC_NSRC-1:0] sw_clr  = clr_cmd.valid ? ~clr_cmd.keep_mask : '0;  // RULE11
  wire [`PIC_NSRC-1:0] ack_clr = start_ack ? winner : '0;          // RULE14

  // Set wins over any clear; nothing but hardware sets
  assign next_latch = (request_latch & ~(sw_clr | ack_clr)) | hw_set; // RULE20 RULE12 RULE10

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (start_ack)
          next_state = ST_ACK1;
        else if (to_wait)
          next_state = ST_WAIT_TC;
      end
      ST_WAIT_TC:
      begin
        if (start_ack)
          next_state = ST_ACK1;
        else if (!req_go)
          next_state = ST_IDLE;
      end
      ST_ACK1:
      begin
        if (icyc_en)
          next_state = ST_ACK2;
      end
      ST_ACK2:
      begin
        if (icyc_en)
          next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst || start_ack)
      div_cnt <= `PIC_DIV_ZERO;
    else
      div_cnt <= div_cnt + 3'h1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state    <= ST_IDLE;
      ack_busy <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      ack_busy <= next_state == ST_ACK1 || next_state == ST_ACK2;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      request_latch <= `PIC_LATCH_RST;                             // RULE9
    else
      request_latch <= next_latch;
  end

  // Master flag: acknowledge clears, return sets, clear variants steer
  always_ff @(posedge clock)
  begin
    if (rst)
      master_enable_flag <= `PIC_MASTER_RST;                       // RULE9
    else if (start_ack)
      master_enable_flag <= 1'b0;                                  // RULE14
    else if (return_from_irq)
      master_enable_flag <= 1'b1;                                  // RULE15
    else if (clr_cmd.valid && clr_cmd.kind == CLR_ENABLE)
      master_enable_flag <= 1'b1;                                  // RULE11
    else if (clr_cmd.valid && clr_cmd.kind == CLR_DISABLE)
      master_enable_flag <= 1'b0;                                  // RULE11
  end

  // Exchange with the accumulator
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      source_enable_mask <= `PIC_EIR_RST;                          // RULE9
      xch_rd_data        <= `PIC_EIR_RST;
    end
    else if (xch_strobe)
    begin
      source_enable_mask <= xch_data;                              // RULE8
      xch_rd_data        <= source_enable_mask;                    // RULE8
    end
  end

  // Acknowledge and return strobes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      win_q             <= '0;
      stack_push        <= 1'b0;
      vector_load       <= 1'b0;
      vector_addr       <= '0;
      branch_status_set <= 1'b0;
      stack_pop         <= 1'b0;
      ack_done          <= 1'b0;
    end
    else
    begin
      if (start_ack)
        win_q <= winner;                                           // RULE21
      stack_push        <= start_ack;                              // RULE14
      vector_load       <= state == ST_ACK1 && icyc_en;            // RULE14
      branch_status_set <= state == ST_ACK1 && icyc_en;            // RULE14
      if (state == ST_ACK1 && icyc_en)
        vector_addr <= vec_of(win_q);                              // RULE3
      ack_done  <= state == ST_ACK2 && icyc_en;                    // RULE13
      stack_pop <= return_from_irq;                                // RULE15
    end
  end

  // Checks
  AST_SET_WINS: assert property (@(posedge clock) disable iff (rst) // RULE20
    (|hw_set) |=> ((request_latch & $past(hw_set)) == $past(hw_set)))
    else $error("request latch lost a hardware set");

  AST_NO_SW_SET: assert property (@(posedge clock) disable iff (rst) // RULE12
    ##1 ((request_latch & ~$past(request_latch) & ~$past(hw_set)) == '0))
    else $error("request latch set without a hardware request");

  AST_MASTER_GATES: assert property (@(posedge clock) disable iff (rst) // RULE4
    stack_push |-> $past(master_enable_flag))
    else $error("acknowledge started with master flag clear");

  AST_ACK_LEN: assert property (@(posedge clock) disable iff (rst) // RULE13
    start_ack |=> (ack_busy && !ack_done)[*8] ##1 (ack_busy && vector_load) ##8 ack_done)
    else $error("acknowledge did not take two instruction cycles");

  AST_VECTOR: assert property (@(posedge clock) disable iff (rst) // RULE3
    start_ack |-> ##9 (vector_load && branch_status_set && vector_addr == $past(win_vec, 9)))
    else $error("wrong entry address after acknowledge");

  AST_HIGH_FIRST: assert property (@(posedge clock) disable iff (rst) // RULE7
    (start_ack && request_latch[`PIC_IDX_EXT_HIGH]) |-> ##9 (vector_addr == `PIC_VEC_EXT_HIGH))
    else $error("high priority pin not served first");

  AST_LOW_LAST: assert property (@(posedge clock) disable iff (rst) // RULE2
    (start_ack && eligible == (`PIC_NSRC'(1) << `PIC_IDX_EXT_LOW))
      |-> ##9 (vector_addr == `PIC_VEC_EXT_LOW))
    else $error("low priority pin vector wrong");

  AST_ACK_CLEARS: assert property (@(posedge clock) disable iff (rst) // RULE14
    (start_ack && !(|(hw_set & winner)))
      |=> (stack_push && !master_enable_flag && (request_latch & $past(winner)) == '0))
    else $error("acknowledge did not clear flag and latch");

  AST_RETURN: assert property (@(posedge clock) disable iff (rst) // RULE15
    (return_from_irq && !start_ack) |=> (master_enable_flag && stack_pop))
    else $error("return did not restore and enable");

  AST_XCH: assert property (@(posedge clock) disable iff (rst) // RULE8
    xch_strobe |=> (xch_rd_data == $past(source_enable_mask)
                    && source_enable_mask == $past(xch_data)))
    else $error("enable mask exchange wrong");

  AST_CLR_MASK: assert property (@(posedge clock) disable iff (rst) // RULE11
    (clr_cmd.valid && !start_ack && hw_set == '0)
      |=> (request_latch == ($past(request_latch) & $past(clr_cmd.keep_mask))))
    else $error("clear mask applied wrongly");

  AST_TIMER_WAIT: assert property (@(posedge clock) disable iff (rst) // RULE13
    stack_push |-> !$past(tc_busy))
    else $error("acknowledge started during timer processing");

  AST_RESET: assert property (@(posedge clock) // RULE9
    rst |=> (request_latch == '0 && !master_enable_flag && source_enable_mask == '0))
    else $error("reset did not clear controller state");

  AST_EN_GATE: assert property (@(posedge clock) disable iff (rst) // RULE5
    start_ack |-> !(winner[`PIC_IDX_SERIAL] && !source_enable_mask[`PIC_EIR_SERIAL])
                  && !(winner[`PIC_IDX_TIMER_ONE] && !source_enable_mask[`PIC_EIR_TIMER_ONE])
                  && !(winner[`PIC_IDX_EXT_LOW] && !source_enable_mask[`PIC_EIR_EXT_LOW]))
    else $error("disabled source accepted");

  AST_PAIR_GATE: assert property (@(posedge clock) disable iff (rst) // RULE6
    (start_ack && !source_enable_mask[`PIC_EIR_TIMER_TWO])
      |-> (!winner[`PIC_IDX_TIMER_TWO] && !winner[`PIC_IDX_INTERVAL]))
    else $error("shared enable bit did not gate both timer sources");

  AST_WIN_FROZEN: assert property (@(posedge clock) disable iff (rst) // RULE21
    (ack_busy && !stack_push) |-> $stable(win_q))
    else $error("winner changed during acknowledge");

  AST_VEC_HOLD: assert property (@(posedge clock) disable iff (rst) // RULE3
    !vector_load |-> $stable(vector_addr))
    else $error("entry address changed without a vector load");

  AST_CYCLE_LEN: assert property (@(posedge clock) disable iff (rst) // RULE19
    vector_load |-> $past(stack_push, 8))
    else $error("instruction cycle is not eight clocks");

  AST_POP: assert property (@(posedge clock) disable iff (rst) // RULE15
    stack_pop |-> $past(return_from_irq))
    else $error("stack restore without a return");

  AST_PIN_LOW: assert property (@(posedge clock) disable iff (rst) // RULE17
    pin_fall[0] |=> request_latch[`PIC_IDX_EXT_LOW])
    else $error("low priority pin edge not latched");

endmodule

// ==== core/pic_defines.svh ====
// Constants of the prioritized interrupt controller
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// Sources and latch positions, highest priority at the top bit
`define PIC_NSRC            6
`define PIC_IDX_EXT_HIGH    5
`define PIC_IDX_SERIAL      4
`define PIC_IDX_TIMER_ONE   3
`define PIC_IDX_TIMER_TWO   2
`define PIC_IDX_INTERVAL    1
`define PIC_IDX_EXT_LOW     0

// Enable mask layout
`define PIC_EIR_W           4
`define PIC_EIR_SERIAL      3
`define PIC_EIR_TIMER_ONE   2
`define PIC_EIR_TIMER_TWO   1
`define PIC_EIR_EXT_LOW     0

// Reset values
`define PIC_EIR_RST         4'h0
`define PIC_LATCH_RST       6'h00
`define PIC_MASTER_RST      1'h0

// Entry addresses: base plus step per priority rank
`define PIC_VEC_BASE        2
`define PIC_VEC_STEP        2
`define PIC_VEC_EXT_HIGH    12'h002
`define PIC_VEC_EXT_LOW     12'h00c

// Instruction cycle: states per cycle, clocks per state
`define PIC_STATES_PER_CYC  4
`define PIC_CLKS_PER_STATE  2
`define PIC_CLKS_PER_CYC    (`PIC_STATES_PER_CYC * `PIC_CLKS_PER_STATE)
`define PIC_DIV_W           3
`define PIC_DIV_LAST        3'h7
`define PIC_DIV_ZERO        3'h0

`endif

// ==== core/pic_pin_sync.sv ====
// Pin synchroniser with falling-edge detection
`timescale 1ns/1ps
`include "pic_defines.svh"

module pic_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clock,  // System clock
  input  wire logic         rst,    // Synchronous reset, active high
  input  wire logic [W-1:0] pin_in, // Asynchronous pin levels
  output logic      [W-1:0] fall    // One-cycle pulse per settled falling edge
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;
  wire  [W-1:0] settled = ~(stage2 ^ stage3);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      level  <= '1;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= (level & ~settled) | (stage3 & settled);
    end
  end

  // Settled low after a settled high
  assign fall = level & settled & ~stage3; // RULE17

endmodule

// ==== core/pic_pkg.sv ====
// Types of the prioritized interrupt controller
package pic_pkg;

  // Latch-clearing instruction variants
  typedef enum logic [1:0] {
    CLR_PLAIN,
    CLR_ENABLE,
    CLR_DISABLE
  } pic_clr_kind_t;

  // Latch-clearing instruction: a 0 in keep_mask clears that latch
  typedef struct packed {
    logic          valid;
    pic_clr_kind_t kind;
    logic [5:0]    keep_mask;
  } pic_clr_cmd_t;

  // Internal request pulses from the peripherals
  typedef struct packed {
    logic serial_done_irq;
    logic timer_one_overflow_irq;
    logic timer_two_overflow_irq;
    logic interval_tick_irq;
  } pic_int_req_t;

  // Acknowledge sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TC,
    ST_ACK1,
    ST_ACK2
  } pic_state_t;

endpackage

// ==== tb/pic_core_model.sv ====
// Core sequencer stand-in: instruction boundaries, timer hold, stack depth
`timescale 1ns/1ps

module pic_core_model (
  input  wire logic       clock,      // System clock
  input  wire logic       rst,        // Synchronous reset
  input  wire logic       run,        // Let instructions execute
  input  wire logic       tc_hold,    // Keep timer processing pending
  input  wire logic       ack_busy,   // Acknowledge in progress
  input  wire logic       stack_push, // Save request
  input  wire logic       stack_pop,  // Restore request
  output logic            inst_end,   // Instruction boundary pulse
  output logic            tc_busy,    // Timer processing pending
  output logic [3:0]      stack_depth // Saved frames
);
  logic [2:0] phase;

  // One instruction per eight clocks, stalled during acknowledge
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase    <= 3'h0;
      inst_end <= 1'b0;
    end
    else
    begin
      phase    <= (run && !ack_busy) ? phase + 3'h1 : 3'h0;
      inst_end <= run && !ack_busy && (phase == 3'h7);
    end
  end

  assign tc_busy = tc_hold;

  // Frames hold PC and flags only; working registers are software's job
  always_ff @(posedge clock)
  begin
    if (rst)
      stack_depth <= 4'h0;
    else if (stack_push)
      stack_depth <= stack_depth + 4'h1;
    else if (stack_pop)
      stack_depth <= stack_depth - 4'h1;
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the prioritized interrupt controller
`timescale 1ns/1ps

module testbench;
  import pic_pkg::*;

  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         pin_hi = 1'b1;
  logic         pin_lo = 1'b1;
  pic_int_req_t int_req = '0;
  pic_clr_cmd_t clr_cmd = '0;
  logic         xch_strobe = 1'b0;
  logic [3:0]   xch_data = 4'h0;
  logic         return_from_irq = 1'b0;
  logic         run = 1'b0;
  logic         tc_hold = 1'b0;
  logic         inst_end, tc_busy, ack_busy, stack_push, vector_load;
  logic         branch_status_set, stack_pop, ack_done, master_enable_flag;
  logic [3:0]   xch_rd_data, source_enable_mask, stack_depth;
  logic [5:0]   request_latch;
  logic [11:0]  vector_addr;
  int           n_errors = 0;
  int           checked = 0;

  always #5 clock = ~clock;

  pic_ctrl pic_ctrl_i (.clock(clock), .rst(rst), .ext_pin_high_prio_irq(pin_hi),
    .ext_pin_low_prio_irq(pin_lo), .int_req(int_req), .inst_end(inst_end),
    .tc_busy(tc_busy), .clr_cmd(clr_cmd), .xch_strobe(xch_strobe), .xch_data(xch_data),
    .return_from_irq(return_from_irq), .xch_rd_data(xch_rd_data),
    .source_enable_mask(source_enable_mask), .master_enable_flag(master_enable_flag),
    .request_latch(request_latch), .ack_busy(ack_busy), .stack_push(stack_push),
    .vector_load(vector_load), .vector_addr(vector_addr),
    .branch_status_set(branch_status_set), .stack_pop(stack_pop), .ack_done(ack_done));

  pic_core_model pic_core_model_i (.clock(clock), .rst(rst), .run(run), .tc_hold(tc_hold),
    .ack_busy(ack_busy), .stack_push(stack_push), .stack_pop(stack_pop),
    .inst_end(inst_end), .tc_busy(tc_busy), .stack_depth(stack_depth));

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic xch(input logic [3:0] d, input logic [3:0] old);
    @(posedge clock);
    xch_strobe <= 1'b1;
    xch_data   <= d;
    @(posedge clock);
    xch_strobe <= 1'b0;
    @(negedge clock);
    chk("xch_rd_data", old, xch_rd_data);
    chk("source_enable_mask", d, source_enable_mask);
  endtask

  task automatic clr(input pic_clr_kind_t k, input logic [5:0] keep, input logic [5:0] lat,
                     input logic m);
    @(posedge clock);
    clr_cmd <= '{1'b1, k, keep};
    @(posedge clock);
    clr_cmd <= '0;
    @(negedge clock);
    chk("request_latch", lat, request_latch);
    chk("master_enable_flag", m, master_enable_flag);
  endtask

  task automatic pulse_req(input logic [3:0] v);
    @(posedge clock);
    int_req <= v;
    @(posedge clock);
    int_req <= '0;
  endtask

  // Pin levels held 20 clocks each, just beyond two instruction cycles
  task automatic pin_fall(input logic hi, input logic lo);
    @(posedge clock);
    pin_hi <= ~hi;
    pin_lo <= ~lo;
    repeat (20) @(posedge clock);
    pin_hi <= 1'b1;
    pin_lo <= 1'b1;
    repeat (20) @(posedge clock);
  endtask

  task automatic idle(input int n);
    @(posedge clock);
    run <= 1'b1;
    repeat (n)
    begin
      @(negedge clock);
      chk("ack_busy", 12'h0, ack_busy);
    end
    @(posedge clock);
    run <= 1'b0;
  endtask

  task automatic ack_one(input logic [11:0] vec, input logic [5:0] lat);
    int n;
    n = 0;
    @(posedge clock);
    run <= 1'b1;
    @(negedge clock);
    while (stack_push !== 1'b1 && n < 64)
    begin
      @(negedge clock);
      n++;
    end
    chk("stack_push", 12'h1, stack_push);
    chk("master_enable_flag", 12'h0, master_enable_flag);
    chk("request_latch", lat, request_latch);
    @(posedge clock);
    run <= 1'b0;
    repeat (8) @(negedge clock);
    chk("vector_load", 12'h1, vector_load);
    chk("branch_status_set", 12'h1, branch_status_set);
    chk("vector_addr", vec, vector_addr);
    chk("ack_busy", 12'h1, ack_busy);
    chk("stack_depth", 12'h1, stack_depth);
    repeat (8) @(negedge clock);
    chk("ack_done", 12'h1, ack_done);
    chk("ack_busy", 12'h0, ack_busy);
    @(posedge clock);
    return_from_irq <= 1'b1;
    @(posedge clock);
    return_from_irq <= 1'b0;
    @(negedge clock);
    chk("stack_pop", 12'h1, stack_pop);
    chk("master_enable_flag", 12'h1, master_enable_flag);
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("request_latch", 12'h0, request_latch);
    chk("source_enable_mask", 12'h0, source_enable_mask);
    chk("master_enable_flag", 12'h0, master_enable_flag);
    xch(4'ha, 4'h0);
    xch(4'hf, 4'ha);
    pin_fall(1'b1, 1'b1);
    pulse_req(4'hf);
    @(negedge clock);
    chk("request_latch", 12'h03f, request_latch);
    clr(CLR_PLAIN, 6'h3f, 6'h3f, 1'b0);
    idle(24);
    clr(CLR_ENABLE, 6'h3f, 6'h3f, 1'b1);
    for (int i = 0; i < 6; i++)
      ack_one(12'h002 + 12'(2 * i), 6'h3f >> (i + 1));
    clr(CLR_PLAIN, 6'h3f, 6'h00, 1'b1);
    pulse_req(4'h3);
    clr(CLR_PLAIN, 6'h3d, 6'h04, 1'b1);
    // Hardware set and clearing instruction on the same latch
    @(posedge clock);
    int_req <= 4'h8;
    clr_cmd <= '{1'b1, CLR_DISABLE, 6'h00};
    @(posedge clock);
    int_req <= '0;
    clr_cmd <= '0;
    @(negedge clock);
    chk("request_latch", 12'h010, request_latch);
    chk("master_enable_flag", 12'h0, master_enable_flag);
    clr(CLR_ENABLE, 6'h3f, 6'h10, 1'b1);
    xch(4'h0, 4'hf);
    idle(24);
    xch(4'h8, 4'h0);
    ack_one(12'h004, 6'h00);
    pulse_req(4'h1);
    xch(4'h2, 4'h8);
    ack_one(12'h00a, 6'h00);
    pulse_req(4'h2);
    ack_one(12'h008, 6'h00);
    xch(4'h0, 4'h2);
    pin_fall(1'b1, 1'b0);
    ack_one(12'h002, 6'h00);
    pulse_req(4'h8);
    xch(4'h8, 4'h0);
    @(posedge clock);
    tc_hold <= 1'b1;
    idle(30);
    tc_hold <= 1'b0;
    ack_one(12'h004, 6'h00);
    // Reset in mid-run with state set
    pulse_req(4'h8);
    @(negedge clock);
    chk("request_latch", 12'h010, request_latch);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("request_latch", 12'h0, request_latch);
    chk("source_enable_mask", 12'h0, source_enable_mask);
    chk("master_enable_flag", 12'h0, master_enable_flag);
    chk("vector_addr", 12'h0, vector_addr);
    end_sim();
  end
endmodule
